// file: odf_pkg.sv
// Purpose: constants for the output driver fault control block
// Assumes: apb slave, 32-bit data, word-aligned registers
// Notes:   offsets below are byte addresses
`default_nettype none
package odf_pkg;
    // register byte addresses
    localparam logic [7:0] HS_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] HS_STAT_ADDR   = 8'h04;
    localparam logic [7:0] LS_CTRL_ADDR   = 8'h08;
    localparam logic [7:0] LS_STAT_ADDR   = 8'h0C;
    localparam logic [7:0] MODE_CTRL_ADDR = 8'h10;
    localparam logic [7:0] IRQ_SRC_ADDR   = 8'h14;
    localparam logic [7:0] IRQ_MASK_ADDR  = 8'h18;
    localparam logic [7:0] IRQ_STAT_ADDR  = 8'h1C;
    localparam int         NUM_REGS       = 8;
    // high-side control fields
    localparam int HS_EN_BIT  = 0;
    localparam int HS_PWM_BIT = 1;
    // low-side control fields
    localparam int LS_A_EN_BIT  = 0;
    localparam int LS_A_PWM_BIT = 1;
    localparam int LS_B_EN_BIT  = 2;
    localparam int LS_B_PWM_BIT = 3;
    // status fields
    localparam int HS_CL_BIT   = 0;
    localparam int HS_OL_BIT   = 1;
    localparam int LS_A_CL_BIT = 0;
    localparam int LS_A_OL_BIT = 1;
    localparam int LS_B_CL_BIT = 2;
    localparam int LS_B_OL_BIT = 3;
    // mode control fields
    localparam int MODE_LSB = 0;
    localparam int OVS_EN_BIT = 2;
    // mask and sticky status fields
    localparam int HS_IRQ_BIT = 0;
    localparam int LS_IRQ_BIT = 1;
    // interrupt source codes
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_HS   = 4'h2;
    localparam logic [3:0] SRC_LS   = 4'h3;
    // operating modes
    localparam logic [1:0] MODE_NORMAL     = 2'h0;
    localparam logic [1:0] MODE_NORMAL_REQ = 2'h1;
    localparam logic [1:0] MODE_STOP       = 2'h2;
    localparam logic [1:0] MODE_SLEEP      = 2'h3;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] MODE_RST = 32'h0000_0001;
endpackage : odf_pkg
`default_nettype wire

// file: odf_reg_mem.sv
// Purpose: small register store with registered read data
// Assumes: one write port, one read port, same clock
// Notes:   holds the software-written control words
`timescale 1ns/1ps
`default_nettype none
module odf_reg_mem (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // write port
    input  wire logic        we_in,
    input  wire logic [2:0]  waddr_in,
    input  wire logic [31:0] wdata_in,
    // read port
    input  wire logic [2:0]  raddr_in,
    output logic      [31:0] rdata_out
);
    logic [31:0] mem_q [odf_pkg::NUM_REGS];
    logic [31:0] rdata_q;

    genvar g;
    generate
        for (g = 0; g < odf_pkg::NUM_REGS; g++) begin : g_word
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    mem_q[g] <= 32'h0000_0000;
                end else if (we_in && (waddr_in == 3'(g))) begin
                    mem_q[g] <= wdata_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= mem_q[raddr_in];
        end
    end

    assign rdata_out = rdata_q;
endmodule // odf_reg_mem
`default_nettype wire

// file: odf_driver_ctrl.sv
// Purpose: on/off control, status flags and fault latching for one high-side and
//          two low-side drivers, with an apb register slave and interrupt output
// Assumes: analog fault inputs are synchronous levels; pwm input synchronous
// Notes:   apb answers with zero wait states; unmapped addresses slverr
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module odf_driver_ctrl (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    // apb slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // direct pwm input
    input  wire logic        DIRECT_PWM_INPUT_IN,
    // analog fault conditions
    input  wire logic        HS_OVERTEMP_IN,
    input  wire logic        HS_OPEN_LOAD_IN,
    input  wire logic        HS_CURRENT_LIMIT_IN,
    input  wire logic        LS_OVERTEMP_IN,
    input  wire logic [1:0]  LS_OPEN_LOAD_IN,
    input  wire logic [1:0]  LS_CURRENT_LIMIT_IN,
    input  wire logic        OVERVOLTAGE_IN,
    // driver gates
    output logic             HS_ON_OUT,
    output logic [1:0]       LS_ON_OUT,
    // interrupts
    output logic             IRQ_N_OUT,
    output logic             IRQ_OUT
);
    logic        acc, wr, rd, hit;
    logic [2:0]  idx;
    logic [31:0] mem_rdata;
    logic        wr_hs, wr_ls, wr_mode, wr_mask, wr_stat;

    logic [1:0]  hs_ctrl_q, hs_ctrl_d;
    logic [3:0]  ls_ctrl_q, ls_ctrl_d;
    logic [1:0]  mode_q, mode_d;
    logic        ovs_en_q, ovs_en_d;
    logic [1:0]  mask_q, mask_d;
    logic [1:0]  sticky_q, sticky_d;
    logic        hs_shut_q, hs_shut_d;
    logic        ls_shut_q, ls_shut_d;
    logic        hs_on_q, hs_on_d;
    logic [1:0]  ls_on_q, ls_on_d;
    logic [1:0]  hs_stat_q, hs_stat_d;
    logic [3:0]  ls_stat_q, ls_stat_d;
    logic [31:0] rdata_q, rdata_d;
    logic        slverr_q, slverr_d;
    logic        irq_mode, normal_mode;
    logic        hs_evt, ls_evt, ov_evt;
    logic        ovt_hs_q, ovt_ls_q, ov_q;
    logic [3:0]  src_code;

    assign acc     = PSEL_IN && PENABLE_IN;
    assign wr      = acc && PWRITE_IN;
    assign rd      = acc && !PWRITE_IN;
    assign idx     = PADDR_IN[4:2];
    assign hit     = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN[7:5] == 3'h0);
    assign wr_hs   = wr && (PADDR_IN == odf_pkg::HS_CTRL_ADDR);
    assign wr_ls   = wr && (PADDR_IN == odf_pkg::LS_CTRL_ADDR);
    assign wr_mode = wr && (PADDR_IN == odf_pkg::MODE_CTRL_ADDR);
    assign wr_mask = wr && (PADDR_IN == odf_pkg::IRQ_MASK_ADDR);
    assign wr_stat = wr && (PADDR_IN == odf_pkg::IRQ_STAT_ADDR);

    // shadow copy of written words, checked against the live high-side control
    odf_reg_mem u_mem (
        .clk_in    (CLK_IN),
        .nrst_in   (NRST_IN),
        .we_in     (wr && hit),
        .waddr_in  (idx),
        .wdata_in  (PWDATA_IN),
        .raddr_in  (idx),
        .rdata_out (mem_rdata)
    );

    assign normal_mode = (mode_q == odf_pkg::MODE_NORMAL) ||
                         (mode_q == odf_pkg::MODE_NORMAL_REQ);
    assign irq_mode    = normal_mode || (mode_q == odf_pkg::MODE_STOP);

    // rising edges of the overtemperature and enabled overvoltage inputs start a latched event
    assign hs_evt = HS_OVERTEMP_IN && !ovt_hs_q;
    assign ls_evt = LS_OVERTEMP_IN && !ovt_ls_q;
    assign ov_evt = OVERVOLTAGE_IN && !ov_q && ovs_en_q;

    always_comb begin
        hs_ctrl_d = hs_ctrl_q;
        ls_ctrl_d = ls_ctrl_q;
        mode_d    = mode_q;
        ovs_en_d  = ovs_en_q;
        mask_d    = mask_q;
        sticky_d  = sticky_q;
        hs_shut_d = hs_shut_q;
        ls_shut_d = ls_shut_q;
        if (wr_hs) begin
            hs_ctrl_d = PWDATA_IN[1:0];
            // rewrite releases only once the cause is gone
            if (!HS_OVERTEMP_IN && !(OVERVOLTAGE_IN && ovs_en_q)) begin
                hs_shut_d = 1'b0;
            end
        end
        if (wr_ls) begin
            ls_ctrl_d = PWDATA_IN[3:0];
            if (!LS_OVERTEMP_IN) begin
                ls_shut_d = 1'b0;
            end
        end
        if (wr_mode) begin
            mode_d   = PWDATA_IN[odf_pkg::MODE_LSB +: 2];
            ovs_en_d = PWDATA_IN[odf_pkg::OVS_EN_BIT];
        end
        if (wr_mask) begin
            mask_d = PWDATA_IN[1:0];
        end
        if (wr_stat) begin
            sticky_d = sticky_q & ~PWDATA_IN[1:0];
        end
        if (HS_OVERTEMP_IN || ov_evt) begin
            hs_shut_d = 1'b1;
        end
        if (LS_OVERTEMP_IN) begin
            ls_shut_d = 1'b1;
        end
        // set beats clear; masked events leave the source clear
        if (hs_evt && irq_mode && mask_q[odf_pkg::HS_IRQ_BIT]) begin
            sticky_d[odf_pkg::HS_IRQ_BIT] = 1'b1;
        end
        if (ls_evt && irq_mode && mask_q[odf_pkg::LS_IRQ_BIT]) begin
            sticky_d[odf_pkg::LS_IRQ_BIT] = 1'b1;
        end
    end

    always_comb begin
        // pwm select gates enable with the direct input
        hs_on_d = hs_ctrl_q[odf_pkg::HS_EN_BIT] &&
                  (!hs_ctrl_q[odf_pkg::HS_PWM_BIT] || DIRECT_PWM_INPUT_IN) &&
                  !hs_shut_q;
        ls_on_d[0] = ls_ctrl_q[odf_pkg::LS_A_EN_BIT] &&
                     (!ls_ctrl_q[odf_pkg::LS_A_PWM_BIT] || DIRECT_PWM_INPUT_IN) &&
                     !ls_shut_q && normal_mode;
        ls_on_d[1] = ls_ctrl_q[odf_pkg::LS_B_EN_BIT] &&
                     (!ls_ctrl_q[odf_pkg::LS_B_PWM_BIT] || DIRECT_PWM_INPUT_IN) &&
                     !ls_shut_q && normal_mode;
        if (hs_shut_q && HS_OVERTEMP_IN) begin
            hs_stat_d = 2'h3;
        end else begin
            hs_stat_d[odf_pkg::HS_OL_BIT] = HS_OPEN_LOAD_IN && normal_mode;
            hs_stat_d[odf_pkg::HS_CL_BIT] = HS_CURRENT_LIMIT_IN;
        end
        if (ls_shut_q && LS_OVERTEMP_IN) begin
            ls_stat_d = 4'hF;
        end else begin
            ls_stat_d[odf_pkg::LS_A_OL_BIT] = LS_OPEN_LOAD_IN[0] && normal_mode;
            ls_stat_d[odf_pkg::LS_B_OL_BIT] = LS_OPEN_LOAD_IN[1] && normal_mode;
            ls_stat_d[odf_pkg::LS_A_CL_BIT] = LS_CURRENT_LIMIT_IN[0];
            ls_stat_d[odf_pkg::LS_B_CL_BIT] = LS_CURRENT_LIMIT_IN[1];
        end
    end

    // high-side source has priority when both are latched
    assign src_code = sticky_q[odf_pkg::HS_IRQ_BIT] ? odf_pkg::SRC_HS :
                      sticky_q[odf_pkg::LS_IRQ_BIT] ? odf_pkg::SRC_LS :
                      odf_pkg::SRC_NONE;

    always_comb begin
        rdata_d  = 32'h0000_0000;
        slverr_d = 1'b0;
        if (!PSEL_IN || PENABLE_IN) begin
            rdata_d = rdata_q;
        end else if (PADDR_IN == odf_pkg::HS_STAT_ADDR) begin
            rdata_d = {30'h0, hs_stat_q};
        end else if (PADDR_IN == odf_pkg::LS_STAT_ADDR) begin
            rdata_d = {28'h0, ls_stat_q};
        end else if (PADDR_IN == odf_pkg::IRQ_SRC_ADDR) begin
            rdata_d = {28'h0, src_code};
        end else if (PADDR_IN == odf_pkg::IRQ_STAT_ADDR) begin
            rdata_d = {30'h0, sticky_q};
        end else if (PADDR_IN == odf_pkg::HS_CTRL_ADDR) begin
            rdata_d = {30'h0, hs_ctrl_q};
        end else if (PADDR_IN == odf_pkg::LS_CTRL_ADDR) begin
            rdata_d = {28'h0, ls_ctrl_q};
        end else if (PADDR_IN == odf_pkg::MODE_CTRL_ADDR) begin
            rdata_d = {29'h0, ovs_en_q, mode_q};
        end else if (PADDR_IN == odf_pkg::IRQ_MASK_ADDR) begin
            rdata_d = {30'h0, mask_q};
        end else begin
            slverr_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            hs_ctrl_q <= odf_pkg::CTRL_RST[1:0];
            ls_ctrl_q <= odf_pkg::CTRL_RST[3:0];
            mode_q    <= odf_pkg::MODE_RST[1:0];
            ovs_en_q  <= odf_pkg::MODE_RST[odf_pkg::OVS_EN_BIT];
            mask_q    <= odf_pkg::MASK_RST[1:0];
            sticky_q  <= 2'h0;
            hs_shut_q <= 1'b0;
            ls_shut_q <= 1'b0;
            hs_on_q   <= 1'b0;
            ls_on_q   <= 2'h0;
            hs_stat_q <= 2'h0;
            ls_stat_q <= 4'h0;
            rdata_q   <= 32'h0000_0000;
            slverr_q  <= 1'b0;
            ovt_hs_q  <= 1'b0;
            ovt_ls_q  <= 1'b0;
            ov_q      <= 1'b0;
        end else begin
            hs_ctrl_q <= hs_ctrl_d;
            ls_ctrl_q <= ls_ctrl_d;
            mode_q    <= mode_d;
            ovs_en_q  <= ovs_en_d;
            mask_q    <= mask_d;
            sticky_q  <= sticky_d;
            hs_shut_q <= hs_shut_d;
            ls_shut_q <= ls_shut_d;
            hs_on_q   <= hs_on_d;
            ls_on_q   <= ls_on_d;
            hs_stat_q <= hs_stat_d;
            ls_stat_q <= ls_stat_d;
            rdata_q   <= rdata_d;
            slverr_q  <= slverr_d;
            ovt_hs_q  <= HS_OVERTEMP_IN;
            ovt_ls_q  <= LS_OVERTEMP_IN;
            ov_q      <= OVERVOLTAGE_IN;
        end
    end

    // data captured at setup, presented in the access phase
    assign PRDATA_OUT  = rdata_q;
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = acc && slverr_q;
    assign HS_ON_OUT   = hs_on_q;
    assign LS_ON_OUT   = ls_on_q;
    assign IRQ_OUT     = |(sticky_q & mask_q);
    assign IRQ_N_OUT   = !IRQ_OUT;

    a_hs_pwm_follow: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (hs_ctrl_q == 2'h3 && !hs_shut_q) |=> (HS_ON_OUT == $past(DIRECT_PWM_INPUT_IN)))
        else $error("high-side not following pwm input");
    a_hs_ctrl_only: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (hs_ctrl_q == 2'h1 && !hs_shut_q) |=> HS_ON_OUT)
        else $error("high-side not on from enable bit");
    a_shadow_match: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (rd && PADDR_IN == odf_pkg::HS_CTRL_ADDR) |-> (mem_rdata[1:0] == hs_ctrl_q))
        else $error("high-side control differs from its shadow word");
    a_hs_ot_off: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        HS_OVERTEMP_IN |=> ##1 !HS_ON_OUT)
        else $error("high-side on during overtemperature");
    a_hs_stay_off: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (hs_shut_q && !wr_hs) |=> hs_shut_q)
        else $error("high-side shutdown released without write");
    a_hs_both_flags: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (hs_shut_q && HS_OVERTEMP_IN) |=> (hs_stat_q == 2'h3))
        else $error("thermal shutdown flags not both set");
    a_hs_ol_mode: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (!normal_mode && !hs_shut_q) |=> !hs_stat_q[odf_pkg::HS_OL_BIT])
        else $error("high-side open load flagged outside normal modes");
    a_hs_cl_clear: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (!HS_CURRENT_LIMIT_IN && !hs_shut_q) |=> !hs_stat_q[odf_pkg::HS_CL_BIT])
        else $error("high-side current limit flag stuck");
    a_ov_hs_off: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (OVERVOLTAGE_IN && !ov_q && ovs_en_q) |=> ##1 !HS_ON_OUT)
        else $error("high-side on after overvoltage shutdown");
    a_ls_ot_flags: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        LS_OVERTEMP_IN |=> ##1 (LS_ON_OUT == 2'h0) ##0
            (ls_stat_q == 4'hF || !$past(LS_OVERTEMP_IN)))
        else $error("low-side overtemperature not handled");
    a_ls_on_limit: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (ls_ctrl_q == 4'h5 && !ls_shut_q && normal_mode) |=> (LS_ON_OUT == 2'h3))
        else $error("low-side dropped while enabled");
    a_masked_quiet: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (mask_q == 2'h0) |-> IRQ_N_OUT)
        else $error("interrupt with all sources masked");
    a_hs_src_code: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (hs_evt && mask_q[0] && irq_mode) |=> (src_code == 4'h2) && !IRQ_N_OUT)
        else $error("high-side source code missing");
    a_sleep_no_irq: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (mode_q == 2'h3 && !wr_stat && !wr_mode) |=> $stable(sticky_q) || $fell(sticky_q[0]))
        else $error("interrupt set in sleep mode");
endmodule // odf_driver_ctrl
`default_nettype wire

// file: odf_mcu_model.sv
// Purpose: microcontroller stand-in that drives the direct pwm pin
// Assumes: shares the block clock; pwm changes just after a rising edge
// Notes:   counts falling edges of the active-low interrupt line
`timescale 1ns/1ps
`default_nettype none
module odf_mcu_model #(
    parameter int HALF_PER = 3
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // pwm generation
    input  wire logic       run_in,
    output logic            pwm_out,
    // interrupt service
    input  wire logic       irq_n_in,
    output logic      [7:0] irq_cnt_out
);
    logic [3:0] ph_q;
    logic       irq_n_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ph_q        <= 4'h0;
            pwm_out     <= 1'b0;
            irq_n_q     <= 1'b1;
            irq_cnt_out <= 8'h00;
        end else begin
            irq_n_q <= irq_n_in;
            if (irq_n_q && !irq_n_in) begin
                irq_cnt_out <= irq_cnt_out + 8'h01;
            end
            if (!run_in) begin
                ph_q    <= 4'h0;
                pwm_out <= 1'b0;
            end else if (ph_q == 4'(HALF_PER)) begin
                ph_q    <= 4'h0;
                pwm_out <= !pwm_out;
            end else begin
                ph_q <= ph_q + 4'h1;
            end
        end
    end
endmodule // odf_mcu_model
`default_nettype wire

// file: output_driver_fault_control_tb.sv
// Purpose: self-checking bench for the driver fault control block
// Assumes: apb answers within a few cycles; fault inputs are levels
// Notes:   outputs are sampled on the falling edge after look, and just after the rising edge after an apb transfer
`timescale 1ns/1ps
`default_nettype none
module output_driver_fault_control_tb;
    logic clk, nrst, psel, pen, pwr, run, hot, ol, cl, lot, ov;
    logic [7:0] paddr, cnt, c0;
    logic [31:0] pwd, prd, rd_v;
    logic pready, perr, er_v, pwm, hs_on, irq_n, irq, prev;
    logic [1:0] lol, lcl, ls_on;
    int err_total, n_compared;

    odf_driver_ctrl u_odf_driver_ctrl (.CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
        .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
        .DIRECT_PWM_INPUT_IN(pwm), .HS_OVERTEMP_IN(hot), .HS_OPEN_LOAD_IN(ol),
        .HS_CURRENT_LIMIT_IN(cl), .LS_OVERTEMP_IN(lot), .LS_OPEN_LOAD_IN(lol),
        .LS_CURRENT_LIMIT_IN(lcl), .OVERVOLTAGE_IN(ov), .HS_ON_OUT(hs_on),
        .LS_ON_OUT(ls_on), .IRQ_N_OUT(irq_n), .IRQ_OUT(irq));
    odf_mcu_model u_odf_mcu_model (.clk_in(clk), .nrst_in(nrst), .run_in(run),
        .pwm_out(pwm), .irq_n_in(irq_n), .irq_cnt_out(cnt));

    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_v = prd;
        er_v = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(exp, rd_v);
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset();
        chk(32'h1, {31'h0, irq_n});
        rdc(odf_pkg::MODE_CTRL_ADDR, odf_pkg::MODE_RST);
        rdc(odf_pkg::IRQ_MASK_ADDR, odf_pkg::MASK_RST);
        rdc(odf_pkg::IRQ_SRC_ADDR, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        chk(32'h1, {31'h0, er_v});
    endtask

    task automatic t_pwm();
        logic [31:0] ctl;
        wr(odf_pkg::HS_CTRL_ADDR, 32'h1);
        look(2);
        chk(32'h1, {31'h0, hs_on});
        rdc(odf_pkg::HS_CTRL_ADDR, 32'h1);
        @(posedge clk);
        run <= 1'b1;
        for (ctl = 32'h2; ctl <= 32'h3; ctl++) begin
            wr(odf_pkg::HS_CTRL_ADDR, ctl);
            look(2);
            repeat (16) begin
                @(posedge clk);
                prev = pwm;
                @(negedge clk);
                chk({31'h0, prev & ctl[0]}, {31'h0, hs_on});
            end
        end
        @(posedge clk);
        run <= 1'b0;
    endtask

    task automatic t_flags();
        wr(odf_pkg::HS_CTRL_ADDR, 32'h1);
        wr(odf_pkg::LS_CTRL_ADDR, 32'h5);
        @(posedge clk);
        ol <= 1'b1;
        look(2);
        rdc(odf_pkg::HS_STAT_ADDR, 32'h2);
        ol <= 1'b0;
        cl <= 1'b1;
        lcl <= 2'b10;
        lol <= 2'b01;
        look(2);
        rdc(odf_pkg::HS_STAT_ADDR, 32'h1);
        chk(32'h1, {31'h0, hs_on});
        rdc(odf_pkg::LS_STAT_ADDR, 32'h6);
        lcl <= 2'b01;
        lol <= 2'b10;
        look(2);
        rdc(odf_pkg::LS_STAT_ADDR, 32'h9);
        chk(32'h3, {30'h0, ls_on});
        cl <= 1'b0;
        lcl <= 2'b00;
        lol <= 2'b00;
        look(2);
        rdc(odf_pkg::HS_STAT_ADDR, 32'h0);
        rdc(odf_pkg::LS_STAT_ADDR, 32'h0);
    endtask

    task automatic t_hs_hot(input logic [31:0] mode, input logic [31:0] mask, input logic up);
        wr(odf_pkg::MODE_CTRL_ADDR, mode);
        wr(odf_pkg::IRQ_MASK_ADDR, mask);
        wr(odf_pkg::HS_CTRL_ADDR, 32'h1);
        c0 = cnt;
        @(posedge clk);
        hot <= 1'b1;
        look(3);
        chk(32'h0, {31'h0, hs_on});
        chk({31'h0, !up}, {31'h0, irq_n});
        chk({31'h0, up}, {31'h0, irq});
        rdc(odf_pkg::HS_STAT_ADDR, 32'h3);
        rdc(odf_pkg::IRQ_SRC_ADDR, up ? 32'h2 : 32'h0);
        wr(odf_pkg::HS_CTRL_ADDR, 32'h1);
        hot <= 1'b0;
        look(2);
        chk(32'h0, {31'h0, hs_on});
        wr(odf_pkg::HS_CTRL_ADDR, 32'h1);
        look(2);
        chk(32'h1, {31'h0, hs_on});
        chk({24'h0, c0 + {7'h0, up}}, {24'h0, cnt});
        wr(odf_pkg::IRQ_STAT_ADDR, 32'h3);
        look(1);
        chk(32'h1, {31'h0, irq_n});
    endtask

    task automatic t_ls_hot();
        wr(odf_pkg::MODE_CTRL_ADDR, 32'h1);
        wr(odf_pkg::IRQ_MASK_ADDR, 32'h2);
        wr(odf_pkg::LS_CTRL_ADDR, 32'h5);
        @(posedge clk);
        lot <= 1'b1;
        look(3);
        chk(32'h0, {30'h0, ls_on});
        chk(32'h0, {31'h0, irq_n});
        rdc(odf_pkg::LS_STAT_ADDR, 32'hF);
        rdc(odf_pkg::IRQ_SRC_ADDR, 32'h3);
        lot <= 1'b0;
        look(2);
        chk(32'h0, {30'h0, ls_on});
        wr(odf_pkg::LS_CTRL_ADDR, 32'h5);
        look(2);
        chk(32'h3, {30'h0, ls_on});
        wr(odf_pkg::IRQ_STAT_ADDR, 32'h2);
    endtask

    task automatic t_ov();
        wr(odf_pkg::MODE_CTRL_ADDR, 32'h5);
        wr(odf_pkg::HS_CTRL_ADDR, 32'h1);
        @(posedge clk);
        ov <= 1'b1;
        look(3);
        chk(32'h0, {31'h0, hs_on});
        wr(odf_pkg::HS_CTRL_ADDR, 32'h1);
        ov <= 1'b0;
        look(2);
        chk(32'h0, {31'h0, hs_on});
        wr(odf_pkg::HS_CTRL_ADDR, 32'h1);
        look(2);
        chk(32'h1, {31'h0, hs_on});
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    initial begin
        {nrst, psel, pen, pwr, run, hot, ol, cl, lot, ov} = '0;
        {paddr, pwd, lol, lcl} = '0;
        err_total = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        look(1);
        t_reset();
        t_pwm();
        t_flags();
        t_hs_hot(32'h1, 32'h0, 1'b0);
        t_hs_hot(32'h0, 32'h1, 1'b1);
        t_hs_hot(32'h2, 32'h1, 1'b1);
        t_hs_hot(32'h3, 32'h1, 1'b0);
        t_ls_hot();
        t_ov();
        give_verdict();
    end
endmodule // output_driver_fault_control_tb
`default_nettype wire
